// ==== bench/tis_irq_ctrl_bench.sv ====
// self-checking bench for the timer interrupt enable, status and clear registers
module tis_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // stimulus and design
  logic sys_clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] rdata;
  logic irq;
  tis_pkg::tis_events_t ev = '0;
  logic [31:0] got;
  logic [31:0] bitv;
  logic [31:0] all = {21'h0, tis_pkg::IMPL_MASK};
  int fail_count = 0;
  int comparisons = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  tis_irq_ctrl dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .events_i(ev), .irq_o(irq));
  // ==========
  // bus and compare tasks
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk_i);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic chk_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk_i);
    rd <= 1'h0;
    @(negedge sys_clk_i);
    chk(what, exp, rdata);
  endtask : chk_reg
  task automatic chk_irq(input logic exp);
    @(negedge sys_clk_i);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : chk_irq
  task automatic pulse(input tis_pkg::tis_events_t e);
    @(posedge sys_clk_i);
    ev <= e;
    @(posedge sys_clk_i);
    ev <= '0;
  endtask : pulse
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========
  // tests
  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'h0;
    chk_reg("enable", tis_pkg::OFS_ENABLE, 32'h0);
    chk_reg("raw", tis_pkg::OFS_RAW, 32'h0);
    chk_irq(1'h0);
    $display("test reset done");
    for (int k = 0; k < 7; k++) begin
      bitv = 32'h1 << (k < 4 ? k : k + 4);
      pulse(tis_pkg::tis_events_t'(7'h01 << k));
      chk_reg("raw", tis_pkg::OFS_RAW, bitv);
      chk_reg("masked", tis_pkg::OFS_MASKED, 32'h0);
      chk_irq(1'h0);
      wr_reg(tis_pkg::OFS_ENABLE, bitv);
      chk_reg("enable", tis_pkg::OFS_ENABLE, bitv);
      chk_reg("masked", tis_pkg::OFS_MASKED, bitv);
      chk_irq(1'h1);
      wr_reg(tis_pkg::OFS_CLEAR, all & ~bitv);
      chk_reg("raw", tis_pkg::OFS_RAW, bitv);
      wr_reg(tis_pkg::OFS_CLEAR, bitv);
      chk_irq(1'h0);
      chk_reg("masked", tis_pkg::OFS_MASKED, 32'h0);
      wr_reg(tis_pkg::OFS_ENABLE, 32'h0);
    end
    $display("test sources done");
    wr_reg(tis_pkg::OFS_ENABLE, all);
    pulse(tis_pkg::tis_events_t'(7'h7F));
    wr_reg(tis_pkg::OFS_RAW, 32'h0);
    wr_reg(tis_pkg::OFS_MASKED, 32'h0);
    chk_reg("raw", tis_pkg::OFS_RAW, all);
    chk_reg("masked", tis_pkg::OFS_MASKED, all);
    chk_reg("unmapped", 12'h100, 32'h0);
    chk_reg("clear", tis_pkg::OFS_CLEAR, 32'h0);
    wr_reg(tis_pkg::OFS_ENABLE, 32'h0000_0305);
    chk_reg("masked", tis_pkg::OFS_MASKED, 32'h0000_0305);
    $display("test read-only done");
    // an event landing with its clear keeps the flag, so no edge is lost
    @(posedge sys_clk_i);
    addr <= tis_pkg::OFS_CLEAR;
    wdata <= all;
    wr <= 1'h1;
    ev <= tis_pkg::tis_events_t'(7'h7F);
    @(posedge sys_clk_i);
    wr <= 1'h0;
    ev <= '0;
    chk_reg("raw", tis_pkg::OFS_RAW, all);
    wr_reg(tis_pkg::OFS_CLEAR, all);
    chk_reg("raw", tis_pkg::OFS_RAW, 32'h0);
    chk_irq(1'h0);
    $display("test set and clear done");
    pulse(tis_pkg::tis_events_t'(7'h7F));
    reset_i <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'h0;
    chk_reg("enable", tis_pkg::OFS_ENABLE, 32'h0);
    chk_reg("raw", tis_pkg::OFS_RAW, 32'h0);
    chk_irq(1'h0);
    $display("test second reset done");
    report_and_stop();
  end
  initial begin
    #20000;
    fail_count++;
    report_and_stop();
  end
endmodule : tis_irq_ctrl_bench

// ==== rtl/tis_flag_bank.sv ====
// sticky flag bank: set by events, cleared by write-one, set wins over clear
module tis_flag_bank #(
  parameter int WIDTH = 11
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clear_i,
  output logic [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // set after clear, so an event in the clearing cycle survives
  assign flags_nxt = (flags_r & ~clear_i) | set_i;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

endmodule : tis_flag_bank

// ==== rtl/tis_irq_ctrl.sv ====
// top: enable, raw, masked and clear registers of the dual timer interrupt logic
// =========================================================
//
// The implementer's own choice: strobed register access.
module tis_irq_ctrl (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire tis_pkg::tis_events_t events_i,
  output logic irq_o
);

  // =========================================================
  // address decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction : hit

  function automatic logic [10:0] impl_bits(input logic [31:0] d);
    impl_bits = d[10:0] & tis_pkg::IMPL_MASK;
  endfunction : impl_bits

  logic [10:0] enable_r;
  logic [10:0] enable_nxt;
  logic [10:0] raw_flags;
  logic [10:0] masked;
  logic [10:0] set_vec;
  logic [10:0] clr_vec;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq_r;

  // =========================================================
  // source to bit mapping
  always_comb begin
    set_vec = '0;
    set_vec[tis_pkg::BIT_A_TIMEOUT] = events_i.a_timeout;
    set_vec[tis_pkg::BIT_A_CAPMATCH] = events_i.a_capmatch;
    set_vec[tis_pkg::BIT_A_CAPEVENT] = events_i.a_capevent;
    set_vec[tis_pkg::BIT_CLOCK_MATCH] = events_i.clock_match;
    set_vec[tis_pkg::BIT_B_TIMEOUT] = events_i.b_timeout;
    set_vec[tis_pkg::BIT_B_CAPMATCH] = events_i.b_capmatch;
    set_vec[tis_pkg::BIT_B_CAPEVENT] = events_i.b_capevent;
  end

  // =========================================================
  // enable register
  // next value also feeds the irq register, so a mask write moves irq_o in the same cycle
  assign enable_nxt = (reg_wr_i && hit(reg_addr_i, tis_pkg::OFS_ENABLE)) ?
    impl_bits(reg_wdata_i) : enable_r;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      enable_r <= tis_pkg::ENABLE_RST;
    end else begin
      enable_r <= enable_nxt;
    end
  end

  // =========================================================
  // raw flags: writes to raw/masked offsets fall through untouched
  assign clr_vec = (reg_wr_i && hit(reg_addr_i, tis_pkg::OFS_CLEAR)) ? impl_bits(reg_wdata_i) : '0;

  tis_flag_bank #(
    .WIDTH(tis_pkg::FLAG_W)
  ) u_flags (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .set_i(set_vec),
    .clear_i(clr_vec),
    .flags_o(raw_flags)
  );

  assign masked = raw_flags & enable_r;

  // =========================================================
  // per-source views, so the per-source checks below read by source rather than by bit
  logic a_timeout_enable;
  logic a_capmatch_enable;
  logic a_capevent_enable;
  logic clock_match_enable;
  logic b_timeout_enable;
  logic b_capmatch_enable;
  logic b_capevent_enable;
  logic a_timeout_raw;
  logic a_capmatch_raw;
  logic a_capevent_raw;
  logic clock_match_raw;
  logic b_timeout_raw;
  logic b_capmatch_raw;
  logic b_capevent_raw;
  logic a_timeout_masked;
  logic a_capmatch_masked;
  logic a_capevent_masked;
  logic clock_match_masked;
  logic b_timeout_masked;
  logic b_capmatch_masked;
  logic b_capevent_masked;
  logic a_timeout_clear;
  logic a_capmatch_clear;
  logic a_capevent_clear;
  logic clock_match_clear;
  logic b_timeout_clear;
  logic b_capmatch_clear;
  logic b_capevent_clear;

  assign a_timeout_enable = enable_r[tis_pkg::BIT_A_TIMEOUT];
  assign a_capmatch_enable = enable_r[tis_pkg::BIT_A_CAPMATCH];
  assign a_capevent_enable = enable_r[tis_pkg::BIT_A_CAPEVENT];
  assign clock_match_enable = enable_r[tis_pkg::BIT_CLOCK_MATCH];
  assign b_timeout_enable = enable_r[tis_pkg::BIT_B_TIMEOUT];
  assign b_capmatch_enable = enable_r[tis_pkg::BIT_B_CAPMATCH];
  assign b_capevent_enable = enable_r[tis_pkg::BIT_B_CAPEVENT];
  assign a_timeout_raw = raw_flags[tis_pkg::BIT_A_TIMEOUT];
  assign a_capmatch_raw = raw_flags[tis_pkg::BIT_A_CAPMATCH];
  assign a_capevent_raw = raw_flags[tis_pkg::BIT_A_CAPEVENT];
  assign clock_match_raw = raw_flags[tis_pkg::BIT_CLOCK_MATCH];
  assign b_timeout_raw = raw_flags[tis_pkg::BIT_B_TIMEOUT];
  assign b_capmatch_raw = raw_flags[tis_pkg::BIT_B_CAPMATCH];
  assign b_capevent_raw = raw_flags[tis_pkg::BIT_B_CAPEVENT];
  assign a_timeout_masked = masked[tis_pkg::BIT_A_TIMEOUT];
  assign a_capmatch_masked = masked[tis_pkg::BIT_A_CAPMATCH];
  assign a_capevent_masked = masked[tis_pkg::BIT_A_CAPEVENT];
  assign clock_match_masked = masked[tis_pkg::BIT_CLOCK_MATCH];
  assign b_timeout_masked = masked[tis_pkg::BIT_B_TIMEOUT];
  assign b_capmatch_masked = masked[tis_pkg::BIT_B_CAPMATCH];
  assign b_capevent_masked = masked[tis_pkg::BIT_B_CAPEVENT];
  assign a_timeout_clear = clr_vec[tis_pkg::BIT_A_TIMEOUT];
  assign a_capmatch_clear = clr_vec[tis_pkg::BIT_A_CAPMATCH];
  assign a_capevent_clear = clr_vec[tis_pkg::BIT_A_CAPEVENT];
  assign clock_match_clear = clr_vec[tis_pkg::BIT_CLOCK_MATCH];
  assign b_timeout_clear = clr_vec[tis_pkg::BIT_B_TIMEOUT];
  assign b_capmatch_clear = clr_vec[tis_pkg::BIT_B_CAPMATCH];
  assign b_capevent_clear = clr_vec[tis_pkg::BIT_B_CAPEVENT];

  // =========================================================
  // interrupt output, registered to keep it glitch free
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((raw_flags & ~clr_vec) | set_vec) & enable_nxt);
    end
  end
  assign irq_o = irq_r;

  // =========================================================
  // read port, data valid the cycle after the strobe only
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd_i) begin
      case (1'b1)
        hit(reg_addr_i, tis_pkg::OFS_ENABLE): rdata_nxt = {21'h0, enable_r};
        hit(reg_addr_i, tis_pkg::OFS_RAW): rdata_nxt = {21'h0, raw_flags};
        hit(reg_addr_i, tis_pkg::OFS_MASKED): rdata_nxt = {21'h0, masked};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata_o = rdata_r;

  // =========================================================
  // checks
  a_enable_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && hit(reg_addr_i, tis_pkg::OFS_ENABLE) |=> enable_r == ($past(reg_wdata_i[10:0]) & tis_pkg::IMPL_MASK))
    else $error("enable register did not take write");
  a_raw_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.a_timeout && !enable_r[0] |=> raw_flags[tis_pkg::BIT_A_TIMEOUT])
    else $error("raw flag not set while disabled");
  a_masked_and: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && hit(reg_addr_i, tis_pkg::OFS_MASKED) |=> reg_rdata_o[10:0] == $past(raw_flags & enable_r))
    else $error("masked read wrong");
  a_clear_one: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clr_vec[8] && !set_vec[8] |=> !raw_flags[8])
    else $error("flag not cleared");
  a_clear_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    raw_flags[3] && !clr_vec[3] |=> raw_flags[3])
    else $error("flag lost without clear");
  a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(reg_rd_i) |-> reg_rdata_o[31:11] == 21'h0 && reg_rdata_o[7:4] == 4'h0)
    else $error("reserved bits not zero");
  a_map_capb: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.b_capevent |=> raw_flags[10])
    else $error("capture b event bit wrong");
  a_ro_raw: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && hit(reg_addr_i, tis_pkg::OFS_RAW) && set_vec == '0 |=> raw_flags == $past(raw_flags))
    else $error("raw register changed by write");
  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    irq_o == |masked)
    else $error("irq not matching masked flags");

  // per-source mapping, clear and interrupt checks
  a_map_timeout_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.a_timeout |=> a_timeout_raw)
    else $error("timer a time-out not on its bit");
  a_map_capmatch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.a_capmatch |=> a_capmatch_raw)
    else $error("capture a match not on its bit");
  a_map_capevent_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.a_capevent |=> a_capevent_raw)
    else $error("capture a event not on its bit");
  a_map_clock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.clock_match |=> clock_match_raw)
    else $error("clock match not on its bit");
  a_map_timeout_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.b_timeout |=> b_timeout_raw)
    else $error("timer b time-out not on its bit");
  a_map_capmatch_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    events_i.b_capmatch |=> b_capmatch_raw)
    else $error("capture b match not on its bit");
  a_clear_timeout_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    a_timeout_clear && !events_i.a_timeout |=> !a_timeout_raw)
    else $error("timer a time-out flag not cleared");
  a_clear_capmatch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    a_capmatch_clear && !events_i.a_capmatch |=> !a_capmatch_raw)
    else $error("capture a match flag not cleared");
  a_clear_capevent_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    a_capevent_clear && !events_i.a_capevent |=> !a_capevent_raw)
    else $error("capture a event flag not cleared");
  a_clear_clock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clock_match_clear && !events_i.clock_match |=> !clock_match_raw)
    else $error("clock match flag not cleared");
  a_clear_capmatch_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    b_capmatch_clear && !events_i.b_capmatch |=> !b_capmatch_raw)
    else $error("capture b match flag not cleared");
  a_clear_capevent_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    b_capevent_clear && !events_i.b_capevent |=> !b_capevent_raw)
    else $error("capture b event flag not cleared");
  a_irq_timeout_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    a_timeout_masked |-> irq_o)
    else $error("timer a time-out did not raise irq");
  a_irq_capmatch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    a_capmatch_masked |-> irq_o)
    else $error("capture a match did not raise irq");
  a_irq_capevent_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    a_capevent_masked |-> irq_o)
    else $error("capture a event did not raise irq");
  a_irq_clock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    clock_match_masked |-> irq_o)
    else $error("clock match did not raise irq");
  a_irq_timeout_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    b_timeout_masked |-> irq_o)
    else $error("timer b time-out did not raise irq");
  a_irq_capmatch_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    b_capmatch_masked |-> irq_o)
    else $error("capture b match did not raise irq");
  a_irq_capevent_b: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    b_capevent_masked |-> irq_o)
    else $error("capture b event did not raise irq");

  // register port checks
  a_enable_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !(reg_wr_i && hit(reg_addr_i, tis_pkg::OFS_ENABLE)) |=> enable_r == $past(enable_r))
    else $error("enable register changed without a write");
  a_enable_rsvd: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (enable_r & ~tis_pkg::IMPL_MASK) == 11'h000)
    else $error("enable register holds an unused bit");
  a_enable_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && hit(reg_addr_i, tis_pkg::OFS_ENABLE) |=> reg_rdata_o[10:0] == $past(enable_r))
    else $error("enable read wrong");
  a_raw_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && hit(reg_addr_i, tis_pkg::OFS_RAW) |=> reg_rdata_o[10:0] == $past(raw_flags))
    else $error("raw read wrong");
  a_clear_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_rd_i && hit(reg_addr_i, tis_pkg::OFS_CLEAR) |=> reg_rdata_o == 32'h0000_0000)
    else $error("clear register read not zero");
  a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero without a read");
  a_ro_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_wr_i && hit(reg_addr_i, tis_pkg::OFS_MASKED) && set_vec == '0 |=> raw_flags == $past(raw_flags))
    else $error("raw flags changed by masked write");
  a_set_wins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    set_vec != 11'h000 |=> (raw_flags & $past(set_vec)) == $past(set_vec))
    else $error("event lost against a clear");
  a_raw_no_spurious: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (raw_flags & ~$past(raw_flags) & ~$past(set_vec)) == 11'h000)
    else $error("raw flag rose without an event");
  a_reset_state: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(reset_i) |-> !irq_o && raw_flags == 11'h000 && enable_r == 11'h000)
    else $error("state not cleared by reset");

endmodule : tis_irq_ctrl

// ==== rtl/tis_pkg.sv ====
// package: register map, field layout and carrier types for the timer interrupt status logic
package tis_pkg;

  // =========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_ENABLE = 12'h018;
  localparam logic [11:0] OFS_RAW = 12'h01C;
  localparam logic [11:0] OFS_MASKED = 12'h020;
  localparam logic [11:0] OFS_CLEAR = 12'h024;

  // =========================================================
  // field positions
  localparam int BIT_A_TIMEOUT = 0;
  localparam int BIT_A_CAPMATCH = 1;
  localparam int BIT_A_CAPEVENT = 2;
  localparam int BIT_CLOCK_MATCH = 3;
  localparam int BIT_B_TIMEOUT = 8;
  localparam int BIT_B_CAPMATCH = 9;
  localparam int BIT_B_CAPEVENT = 10;
  localparam int FLAG_W = 11;
  localparam logic [10:0] IMPL_MASK = 11'h70F;

  // =========================================================
  // reset values
  localparam logic [10:0] ENABLE_RST = 11'h000;
  localparam logic [10:0] RAW_RST = 11'h000;

  // =========================================================
  // carriers
  typedef struct packed {
    logic b_capevent;
    logic b_capmatch;
    logic b_timeout;
    logic clock_match;
    logic a_capevent;
    logic a_capmatch;
    logic a_timeout;
  } tis_events_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tis_bus_req_t;

endpackage : tis_pkg
